//--- rtl/upspc_pkg.sv
package upspc_pkg;

    // Clock rate and the timing figures, each followed by its cycle count.
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned CDP_RESP_MS    = 20;
    localparam int unsigned CDP_RESP_CYC   = CLK_HZ / 1000 * CDP_RESP_MS;
    localparam int unsigned DISCH_US       = 1000;
    localparam int unsigned DISCH_CYC      = CLK_HZ / 1_000_000 * DISCH_US;
    localparam int unsigned RECOV_MS       = 100;
    localparam int unsigned RECOV_CYC      = CLK_HZ / 1000 * RECOV_MS;
    // Cycles from a pin change to its registered response.
    localparam int unsigned SYNC_LAT_CYC   = 4;
    localparam int unsigned DISCH_OHMS     = 100;

    // Reset values of the supply switch outputs and the fault alert.
    localparam logic RST_SWITCH  = 1'b0;
    localparam logic RST_ALERT_N = 1'b1;

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic port_power_enable;
        logic latch_select;
        logic detect_feature_enable;
        logic mode_select_hi;
        logic mode_select_lo;
        logic emulation_enable;
        logic source_uvlo;
        logic over_current;
        logic source_over_voltage;
        logic bus_under_voltage;
        logic back_voltage;
        logic over_temp;
        logic bus_below_check;
        logic attach_sense;
        logic removal_sense;
        logic plus_line_window;
    } upspc_pins_t;

    // Power states of the controller.
    typedef enum logic [2:0] {
        ST_SLEEP  = 3'h0,
        ST_DETECT = 3'h1,
        ST_DISCH  = 3'h2,
        ST_ACTIVE = 3'h3,
        ST_ERROR  = 3'h4
    } upspc_state_t;

    // Decoded Active modes and Sleep.
    typedef enum logic [2:0] {
        K_SLEEP = 3'h0,
        K_DCE   = 3'h1,
        K_PASS  = 3'h2,
        K_DCP   = 3'h3,
        K_SDP   = 3'h4,
        K_CDP   = 3'h5
    } upspc_kind_t;

    // Mode decode from hi, lo and emulation enable.
    function automatic upspc_kind_t upspc_decode(input logic [2:0] code);
        case (code)
            3'h1, 3'h5: return K_DCE;
            3'h2, 3'h6: return K_PASS;
            3'h3:       return K_DCP;
            3'h4:       return K_SDP;
            3'h7:       return K_CDP;
            default:    return K_SLEEP;
        endcase
    endfunction

endpackage

//--- rtl/upspc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module upspc_ctrl
#(
    parameter int unsigned DISCH_CYCLES   = upspc_pkg::DISCH_CYC,
    parameter int unsigned RECOV_CYCLES   = upspc_pkg::RECOV_CYC,
    parameter bit          HAS_ATTACH_PIN = 1'b1
)
(
    // Clock and reset.
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    // Asynchronous pins.
    input  wire upspc_pkg::upspc_pins_t pins_i,
    // Supply and data path controls.
    output logic                    main_switch_o,
    output logic                    bypass_switch_o,
    output logic                    discharge_o,
    output logic                    data_switch_o,
    output logic                    cc_limit_o,
    output logic                    emulation_o,
    output logic                    minus_line_drive_o,
    // Status.
    output logic                    fault_alert_n_o,
    output logic                    attach_indicator_n_o,
    output logic                    attach_flag_o,
    output logic                    discharge_error_o
);
    import upspc_pkg::*;

    localparam int unsigned NPIN = $bits(upspc_pins_t);

    // A discharge shorter than the pin latency would test a stale bus level.
    if (DISCH_CYCLES < SYNC_LAT_CYC + 2 || RECOV_CYCLES < 1 || SYNC_LAT_CYC > CDP_RESP_CYC
        || SYNC_LAT_CYC > 7)
    begin : g_bad_param
        $error("upspc_ctrl: timing parameters out of range.");
    end

    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    logic [NPIN-1:0] pin_ff;
    upspc_pins_t     p;

    // Three-stage sync; a level counts only once stages two and three agree.
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
        always_ff @(posedge clk_i or posedge reset_i)
        begin
            if (reset_i)
            begin
                s1_ff[i]  <= 1'b0;
                s2_ff[i]  <= 1'b0;
                s3_ff[i]  <= 1'b0;
                pin_ff[i] <= 1'b0;
            end
            else
            begin
                s1_ff[i] <= pins_i[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                if (s2_ff[i] == s3_ff[i])
                    pin_ff[i] <= s3_ff[i];
            end
        end
    end
    assign p = upspc_pins_t'(pin_ff);

    upspc_state_t state_ff;
    upspc_state_t dest_ff;
    upspc_kind_t  cur_kind_ff;
    upspc_kind_t  kind;
    logic [31:0]  timer_ff;
    logic         en_d_ff;
    logic         en_fall;
    logic         fault_now;
    logic         removal_evt;
    logic         attach_ff;
    logic         disch_done;
    logic         recov_done;
    logic [2:0]   prime_ff;

    // Mode pins decode straight to an Active mode, or to Sleep.
    assign kind = upspc_decode({p.mode_select_hi, p.mode_select_lo, p.emulation_enable});

    // Over-current is a fault only while trip limiting is in use.
    assign fault_now = (p.over_current & ~cc_limit_o) | p.source_over_voltage
                     | p.bus_under_voltage | p.back_voltage | p.over_temp;

    // Removal watch covers Detect and Active, gated by the feature enable.
    assign removal_evt = p.detect_feature_enable & p.removal_sense
                       & (state_ff == ST_DETECT || state_ff == ST_ACTIVE);

    assign en_fall    = en_d_ff & ~p.port_power_enable;
    assign disch_done = (timer_ff == 32'(DISCH_CYCLES - 1));
    assign recov_done = (timer_ff == 32'(RECOV_CYCLES - 1));

    // Synced pins read zero until the pipeline fills, and zero decodes as Sleep.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            prime_ff <= 3'h0;
        else if (prime_ff != 3'(SYNC_LAT_CYC))
            prime_ff <= prime_ff + 3'h1;
    end

    // Previous enable level for edge detection.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            en_d_ff <= 1'b0;
        else
            en_d_ff <= p.port_power_enable;
    end

    // Power state machine; every path between supplies passes a discharge.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_ff          <= ST_DETECT;
            dest_ff           <= ST_DETECT;
            cur_kind_ff       <= K_SLEEP;
            timer_ff          <= 32'h0;
            discharge_error_o <= 1'b0;
            fault_alert_n_o   <= RST_ALERT_N;
        end
        else
        begin
            case (state_ff)
                ST_SLEEP:
                begin
                    if (kind != K_SLEEP)
                        state_ff <= ST_DETECT;
                end
                ST_DETECT:
                begin
                    timer_ff    <= 32'h0;
                    cur_kind_ff <= kind;
                    if (kind == K_SLEEP && prime_ff == 3'(SYNC_LAT_CYC))
                    begin
                        state_ff <= ST_DISCH;
                        dest_ff  <= ST_SLEEP;
                    end
                    else if (removal_evt)
                    begin
                        state_ff <= ST_DISCH;
                        dest_ff  <= ST_DETECT;
                    end
                    else if (attach_ff && p.port_power_enable && !p.source_uvlo)
                    begin
                        state_ff <= ST_DISCH;
                        dest_ff  <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE:
                begin
                    timer_ff <= 32'h0;
                    if (fault_now)
                    begin
                        state_ff        <= ST_ERROR;
                        fault_alert_n_o <= 1'b0;
                    end
                    else if (p.source_uvlo || removal_evt)
                    begin
                        state_ff <= ST_DISCH;
                        dest_ff  <= ST_DETECT;
                    end
                    else if (kind == K_SLEEP)
                    begin
                        state_ff <= ST_DISCH;
                        dest_ff  <= ST_SLEEP;
                    end
                    else if (kind != cur_kind_ff)
                    begin
                        // Pass-through is entered without a discharge.
                        cur_kind_ff <= kind;
                        if (kind != K_PASS)
                        begin
                            state_ff <= ST_DISCH;
                            dest_ff  <= ST_ACTIVE;
                        end
                    end
                    else if (en_fall && cur_kind_ff != K_PASS)
                    begin
                        // Pass-through ignores an enable fall, and a later mode change does not act on it.
                        state_ff <= ST_DISCH;
                        dest_ff  <= ST_DETECT;
                    end
                end
                ST_DISCH:
                begin
                    timer_ff <= timer_ff + 32'h1;
                    if (disch_done)
                    begin
                        timer_ff <= 32'h0;
                        if (!p.bus_below_check)
                        begin
                            state_ff          <= ST_ERROR;
                            discharge_error_o <= 1'b1;
                            fault_alert_n_o   <= 1'b0;
                        end
                        else
                            state_ff <= dest_ff;
                    end
                end
                ST_ERROR:
                begin
                    if (!p.latch_select)
                    begin
                        timer_ff <= timer_ff + 32'h1;
                        if (recov_done)
                        begin
                            timer_ff <= 32'h0;
                            if (!fault_now)
                            begin
                                state_ff          <= ST_DISCH;
                                dest_ff           <= ST_ACTIVE;
                                discharge_error_o <= 1'b0;
                                fault_alert_n_o   <= 1'b1;
                            end
                        end
                    end
                    else
                    begin
                        // One test per enable falling edge; the host repeats it.
                        timer_ff <= 32'h0;
                        if (en_fall && !fault_now)
                        begin
                            state_ff          <= ST_DISCH;
                            dest_ff           <= ST_ACTIVE;
                            discharge_error_o <= 1'b0;
                            fault_alert_n_o   <= 1'b1;
                        end
                    end
                end
                default:
                    state_ff <= ST_DETECT;
            endcase
        end
    end

    // Attach flag; a new attach wins over a removal in the same cycle.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            attach_ff <= 1'b0;
        else if (state_ff == ST_DETECT && bypass_switch_o && p.attach_sense)
            attach_ff <= 1'b1;
        else if (removal_evt)
            attach_ff <= 1'b0;
    end

    // Registered switch and profile outputs follow the power state.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            main_switch_o        <= RST_SWITCH;
            bypass_switch_o      <= RST_SWITCH;
            discharge_o          <= 1'b0;
            data_switch_o        <= 1'b0;
            cc_limit_o           <= 1'b0;
            emulation_o          <= 1'b0;
            attach_flag_o        <= 1'b0;
            attach_indicator_n_o <= 1'b1;
        end
        else
        begin
            main_switch_o   <= (state_ff == ST_ACTIVE);
            bypass_switch_o <= (state_ff == ST_DETECT);
            discharge_o     <= (state_ff == ST_DISCH);
            data_switch_o   <= (state_ff == ST_ACTIVE)
                             && (cur_kind_ff inside {K_PASS, K_SDP, K_CDP});
            cc_limit_o      <= (state_ff == ST_ACTIVE)
                             && (cur_kind_ff inside {K_CDP, K_DCP, K_DCE});
            emulation_o     <= (state_ff == ST_ACTIVE)
                             && (cur_kind_ff inside {K_CDP, K_DCP, K_DCE});
            attach_flag_o        <= attach_ff;
            attach_indicator_n_o <= HAS_ATTACH_PIN ? ~attach_ff : 1'b1;
        end
    end

    // CDP answer follows the plus line; sync delay is far inside the limit.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            minus_line_drive_o <= 1'b0;
        else
            minus_line_drive_o <= (state_ff == ST_ACTIVE) && (cur_kind_ff == K_CDP)
                                && p.plus_line_window;
    end

    switch_excl_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !(main_switch_o && bypass_switch_o)) else $error("Both supply switches on.");

    detect_open_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_DETECT |=> !data_switch_o && !emulation_o)
        else $error("Data switch or emulation in Detect.");

    disch_check_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_DISCH && disch_done && !p.bus_below_check
        |=> state_ff == ST_ERROR && discharge_error_o) else $error("Missed discharge error.");

    error_alert_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_ERROR |-> !fault_alert_n_o) else $error("Error without alert.");

    enable_fall_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_ACTIVE && en_fall && kind == cur_kind_ff && cur_kind_ff != K_PASS
        |=> state_ff inside {ST_DISCH, ST_ERROR}) else $error("No discharge on enable off.");

    latch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_ERROR && p.latch_select && !en_fall |=> state_ff == ST_ERROR)
        else $error("Latched error left without command.");

    removal_go_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_ACTIVE && removal_evt && !fault_now && !p.source_uvlo
        |=> state_ff == ST_DISCH && dest_ff == ST_DETECT) else $error("Removal ignored.");

    attach_pin_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(attach_ff) |=> attach_indicator_n_o == !HAS_ATTACH_PIN)
        else $error("Attach indicator wrong.");

    cdp_answer_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_ACTIVE && cur_kind_ff == K_CDP && $rose(p.plus_line_window)
        && !fault_now ##1 state_ff == ST_ACTIVE |-> minus_line_drive_o)
        else $error("CDP minus line late.");

    sleep_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_SLEEP [*2] |-> !main_switch_o && !bypass_switch_o)
        else $error("Switch on in Sleep.");

endmodule // upspc_ctrl

`default_nettype wire

//--- verification/upspc_port_model.sv
`timescale 1ns/1ns
`default_nettype none

module upspc_port_model
(
    // Clock.
    input  wire logic clk_i,
    // Commands from the bench.
    input  wire logic present_i,
    input  wire logic plus_req_i,
    input  wire logic stuck_i,
    // Supply state from the controller.
    input  wire logic discharge_i,
    input  wire logic main_switch_i,
    input  wire logic bypass_switch_i,
    // Sensed levels back to the controller.
    output logic      attach_sense_o,
    output logic      removal_sense_o,
    output logic      plus_window_o,
    output logic      bus_below_o
);
    logic [1:0] drain_ff = 2'h0;
    logic [2:0] seen_ff  = 3'h0;

    // The bus needs two discharge cycles to fall and stays low until a switch closes.
    // A stuck bus never falls, which is the only wrong answer the bench can order.
    always_ff @(posedge clk_i)
    begin
        if (main_switch_i || bypass_switch_i || stuck_i)
            drain_ff <= 2'h0;
        else if (discharge_i && drain_ff != 2'h2)
            drain_ff <= drain_ff + 2'h1;
    end

    // History of presence, so an unplug shows as a three-cycle removal pulse.
    always_ff @(posedge clk_i)
    begin
        seen_ff <= {seen_ff[1:0], present_i};
    end

    // A device is only seen while the port powers it.
    assign attach_sense_o  = present_i & bypass_switch_i;
    assign removal_sense_o = (|seen_ff) & ~present_i;
    assign plus_window_o   = plus_req_i & main_switch_i;
    assign bus_below_o     = (drain_ff == 2'h2);
endmodule // upspc_port_model

`default_nettype wire

//--- verification/usb_port_power_state_control_test.sv
`timescale 1ns/1ns
`default_nettype none

module usb_port_power_state_control_test;
    import upspc_pkg::*;
    logic        clk_i      = 1'b0;
    logic        reset_i    = 1'b1;
    upspc_pins_t host       = '0;
    upspc_pins_t pins;
    logic        present    = 1'b0;
    logic        plus_req   = 1'b0;
    logic        stuck      = 1'b0;
    logic        disch_seen = 1'b0;
    logic        att_s, rem_s, plus_w, below;
    logic        main_o, byp_o, dis_o, data_o, cc_o, em_o, minus_o;
    logic        alert_n, attach_n, flag_o, derr_o;
    int          mismatches   = 0;
    int          total_checks = 0;
    logic [2:0]  walk [8] = '{3'h2, 3'h6, 3'h4, 3'h3, 3'h7, 3'h1, 3'h5, 3'h2};
    logic [2:0]  code;

    // Short discharge and recovery counts keep the run brief.
    upspc_ctrl #(.DISCH_CYCLES(12), .RECOV_CYCLES(8), .HAS_ATTACH_PIN(1'b1)) dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins), .main_switch_o(main_o),
        .bypass_switch_o(byp_o), .discharge_o(dis_o), .data_switch_o(data_o),
        .cc_limit_o(cc_o), .emulation_o(em_o), .minus_line_drive_o(minus_o),
        .fault_alert_n_o(alert_n), .attach_indicator_n_o(attach_n),
        .attach_flag_o(flag_o), .discharge_error_o(derr_o));

    upspc_port_model dev_u (
        .clk_i(clk_i), .present_i(present), .plus_req_i(plus_req), .stuck_i(stuck),
        .discharge_i(dis_o), .main_switch_i(main_o), .bypass_switch_i(byp_o),
        .attach_sense_o(att_s), .removal_sense_o(rem_s), .plus_window_o(plus_w),
        .bus_below_o(below));

    // Host pins come from the bench, sensed pins from the device model.
    always_comb
    begin
        pins                  = host;
        pins.attach_sense     = att_s;
        pins.removal_sense    = rem_s;
        pins.plus_line_window = plus_w;
        pins.bus_below_check  = below;
    end

    // Clock, and a note of any discharge since the bench last cleared it.
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (dis_o === 1'b1) disch_seen <= 1'b1;

    // Both supply switches on at once would back-feed one supply into the other.
    always @(negedge clk_i)
        if (!reset_i && main_o === 1'b1 && byp_o === 1'b1) chk("both_switches", 1'b0, 1'b1);

    task automatic final_report();
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Selects an output by number so one bounded wait serves them all.
    function automatic logic out_of(input int sel);
        case (sel)
            0: return main_o;
            1: return byp_o;
            2: return dis_o;
            3: return minus_o;
            4: return alert_n;
            default: return derr_o;
        endcase
    endfunction

    task automatic wait_for(input int sel, input logic val, input int bound);
        int n;
        n = 0;
        while (out_of(sel) !== val && n < bound)
        begin
            @(negedge clk_i);
            n++;
        end
        chk($sformatf("wait_%0d", sel), val, out_of(sel));
        if (out_of(sel) !== val) final_report();
    endtask

    // Expected data switch, constant-current limit and emulation for a mode code.
    function automatic logic [2:0] mode_out(input logic [2:0] c);
        if (c == 3'h2 || c == 3'h6 || c == 3'h4) return 3'h4;
        if (c == 3'h7) return 3'h7;
        return 3'h3;
    endfunction

    // Pass codes are one mode, and so are the two emulation-cycle codes.
    function automatic logic same_mode(input logic [2:0] a, input logic [2:0] b);
        return a == b || mode_out(a) == 3'h4 && mode_out(b) == 3'h4 && a != 3'h4 && b != 3'h4
            || (a == 3'h1 || a == 3'h5) && (b == 3'h1 || b == 3'h5);
    endfunction

    task automatic set_mode(input logic [2:0] c);
        host.mode_select_hi   = c[2];
        host.mode_select_lo   = c[1];
        host.emulation_enable = c[0];
        disch_seen            = 1'b0;
    endtask

    task automatic mode_ok(input logic [2:0] c);
        logic [2:0] e;
        e = mode_out(c);
        chk("data_switch", e[2], data_o);
        chk("cc_limit", e[1], cc_o);
        chk("emulation", e[0], em_o);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Main sequence; every input moves at the falling edge.
    initial
    begin
        void'($urandom(32'h5C11));
        host.port_power_enable     = 1'b1;
        host.detect_feature_enable = 1'b1;
        // A pass-through code keeps the port in Detect instead of Sleep.
        set_mode(3'h2);
        cyc(16);
        reset_i = 1'b0;
        chk("main_rst", 1'b0, main_o);
        chk("alert_rst", 1'b1, alert_n);
        chk("attach_rst", 1'b1, attach_n);
        cyc(3);
        chk("bypass_det", 1'b1, byp_o);
        chk("data_det", 1'b0, data_o);
        chk("em_det", 1'b0, em_o);
        cyc(20);
        chk("idle_main", 1'b0, main_o);
        // Attach in a random mode, then walk every mode code except the Sleep code.
        code = walk[$urandom_range(4, 2)];
        set_mode(code);
        present = 1'b1;
        wait_for(0, 1'b1, 60);
        chk("disch_switchover", 1'b1, disch_seen);
        chk("attach_n", 1'b0, attach_n);
        chk("attach_flag", 1'b1, flag_o);
        mode_ok(code);
        foreach (walk[i])
        begin
            set_mode(walk[i]);
            cyc(14);
            wait_for(0, 1'b1, 30);
            chk("mode_disch", !same_mode(walk[i], code) && mode_out(walk[i]) != 3'h4
                || walk[i] == 3'h4 && code != 3'h4, disch_seen);
            mode_ok(walk[i]);
            code = walk[i];
        end
        // CDP handshake on the data lines.
        set_mode(3'h7);
        cyc(14);
        wait_for(0, 1'b1, 30);
        chk("minus_idle", 1'b0, minus_o);
        plus_req = 1'b1;
        wait_for(3, 1'b1, 20);
        plus_req = 1'b0;
        wait_for(3, 1'b0, 20);
        // Auto-recovery faults; over-current is ignored under constant-current limiting.
        for (int b = 4; b < 8; b++)
        begin
            host[b] = 1'b1;
            wait_for(4, 1'b0, 12);
            wait_for(0, 1'b0, 3);
            host[b] = 1'b0;
            wait_for(4, 1'b1, 60);
            wait_for(0, 1'b1, 40);
        end
        host.over_current = 1'b1;
        cyc(15);
        chk("oc_in_cc", 1'b1, alert_n);
        host.over_current = 1'b0;
        set_mode(3'h2);
        cyc(10);
        host.over_current = 1'b1;
        wait_for(4, 1'b0, 12);
        // The main switch opens one edge after the alert.
        cyc(1);
        chk("oc_trip_main", 1'b0, main_o);
        host.over_current = 1'b0;
        wait_for(0, 1'b1, 60);
        // Latched handling: only an enable fall with the fault gone restores.
        host.latch_select = 1'b1;
        host.over_temp = 1'b1;
        wait_for(4, 1'b0, 12);
        host.port_power_enable = 1'b0;
        cyc(4);
        host.port_power_enable = 1'b1;
        cyc(30);
        chk("latch_held", 1'b0, alert_n);
        host.over_temp = 1'b0;
        cyc(30);
        chk("latch_wait", 1'b0, main_o);
        host.port_power_enable = 1'b0;
        cyc(4);
        host.port_power_enable = 1'b1;
        wait_for(4, 1'b1, 40);
        wait_for(0, 1'b1, 40);
        // A bus that will not discharge raises the discharge error.
        host.latch_select = 1'b0;
        stuck = 1'b1;
        set_mode(3'h4);
        wait_for(5, 1'b1, 30);
        chk("derr_alert", 1'b0, alert_n);
        stuck = 1'b0;
        wait_for(4, 1'b1, 60);
        wait_for(0, 1'b1, 40);
        chk("derr_clear", 1'b0, derr_o);
        // Enable fall outside pass-through discharges and falls back to Detect.
        disch_seen = 1'b0;
        host.port_power_enable = 1'b0;
        wait_for(1, 1'b1, 30);
        chk("en_fall_disch", 1'b1, disch_seen);
        cyc(25);
        chk("wait_enable", 1'b0, main_o);
        host.port_power_enable = 1'b1;
        wait_for(0, 1'b1, 40);
        // Removal is ignored with the feature off, acted on with it on.
        host.detect_feature_enable = 1'b0;
        present = 1'b0;
        cyc(15);
        chk("removal_off", 1'b1, main_o);
        present = 1'b1;
        cyc(2);
        host.detect_feature_enable = 1'b1;
        cyc(6);
        disch_seen = 1'b0;
        present = 1'b0;
        wait_for(0, 1'b0, 12);
        chk("removal_attach", 1'b1, attach_n);
        wait_for(1, 1'b1, 30);
        chk("removal_disch", 1'b1, disch_seen);
        present = 1'b1;
        wait_for(0, 1'b1, 60);
        // Sleep code discharges, then keeps both switches open.
        set_mode(3'h0);
        wait_for(2, 1'b1, 15);
        wait_for(2, 1'b0, 20);
        cyc(2);
        chk("sleep_main", 1'b0, main_o);
        chk("sleep_bypass", 1'b0, byp_o);
        set_mode(3'h2);
        wait_for(0, 1'b1, 60);
        // Source undervoltage in Active discharges the bus.
        host.source_uvlo = 1'b1;
        wait_for(2, 1'b1, 15);
        chk("uvlo_main", 1'b0, main_o);
        final_report();
    end
endmodule // usb_port_power_state_control_test

`default_nettype wire
